// >>> design/smms_axil_slave.sv
// smms_axil_slave: axi4-lite slave front end, single outstanding read and single outstanding write
// assumes: register file in the top answers reads combinationally
`timescale 1ns/1ps
module smms_axil_slave (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);

	// ==========================================================
	// write path: latch aw and w separately, act when both held
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_q, next_aw_q;
	logic [31:0] w_q, next_w_q;
	logic [3:0] s_q, next_s_q;
	logic bv, next_bv;
	logic [1:0] br, next_br;

	assign s_axi_awready = !aw_held && !bv;
	assign s_axi_wready = !w_held && !bv;
	assign wr_en = aw_held && w_held && !bv;
	assign wr_addr = aw_q;
	assign wr_data = w_q;
	assign wr_strb = s_q;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_q = aw_q;
		next_w_q = w_q;
		next_s_q = s_q;
		next_bv = bv;
		next_br = br;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_q = s_axi_wdata;
			next_s_q = s_axi_wstrb;
		end
		if (wr_en) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bv = 1'b1;
			next_br = wr_ok ? 2'h0 : 2'h2;
		end else if (bv && s_axi_bready) begin
			next_bv = 1'b0;
		end
	end

	// ==========================================================
	// read path
	smms_pkg::smms_ax_state_t rs, next_rs;
	logic [31:0] rd_q, next_rd_q;
	logic [1:0] rr, next_rr;

	assign s_axi_arready = (rs == smms_pkg::SMMS_AX_IDLE);
	assign rd_en = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;

	always_comb begin
		next_rs = rs;
		next_rd_q = rd_q;
		next_rr = rr;
		case (rs)
			smms_pkg::SMMS_AX_IDLE: begin
				if (rd_en) begin
					next_rs = smms_pkg::SMMS_AX_RESP;
					next_rd_q = rd_ok ? rd_data : 32'h0000_0000;
					next_rr = rd_ok ? 2'h0 : 2'h2;
				end
			end
			smms_pkg::SMMS_AX_RESP: begin
				if (s_axi_rready) begin
					next_rs = smms_pkg::SMMS_AX_IDLE;
				end
			end
			default: begin
				next_rs = smms_pkg::SMMS_AX_IDLE;
			end
		endcase
	end

	assign s_axi_rvalid = (rs == smms_pkg::SMMS_AX_RESP);
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr;
	assign s_axi_bvalid = bv;
	assign s_axi_bresp = br;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			s_q <= 4'h0;
			bv <= 1'b0;
			br <= 2'h0;
			rs <= smms_pkg::SMMS_AX_IDLE;
			rd_q <= 32'h0000_0000;
			rr <= 2'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_q <= next_aw_q;
			w_q <= next_w_q;
			s_q <= next_s_q;
			bv <= next_bv;
			br <= next_br;
			rs <= next_rs;
			rd_q <= next_rd_q;
			rr <= next_rr;
		end
	end

endmodule

// >>> design/smms_pkg.sv
// smms_pkg: register map, field positions, reset values and enums
// assumes: 32-bit axi4-lite register bus, one 10 MHz system clock
package smms_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned WDOG_DEF_MS = 500;
	localparam logic [31:0] WDOG_DEF_CYC =
		32'(longint'(WDOG_DEF_MS) * CLK_HZ / 1000);

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MOTOR = 8'h04;
	localparam logic [7:0] OFS_SOL = 8'h08;
	localparam logic [7:0] OFS_SENSE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_TO_STAPLE = 8'h18;
	localparam logic [7:0] OFS_TO_GUIDE = 8'h1C;
	localparam logic [7:0] OFS_TO_PADDLE_F = 8'h20;
	localparam logic [7:0] OFS_TO_PADDLE_R = 8'h24;
	localparam logic [7:0] OFS_TO_LIFT_U = 8'h28;
	localparam logic [7:0] OFS_TO_LIFT_D = 8'h2C;

	// ==========================================================
	// field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_STAPLE_EN = 1;
	// motor register: 2 bits per motor, bit0 run, bit1 reverse
	localparam int MOT_STAPLE = 0;
	localparam int MOT_GUIDE = 2;
	localparam int MOT_PADDLE = 4;
	localparam int MOT_FEED = 6;
	localparam int MOT_LIFT = 8;
	localparam int NUM_WDOG = 6;
	// status bits: one per watchdog channel
	localparam int ST_STAPLE = 0;
	localparam int ST_GUIDE = 1;
	localparam int ST_PADDLE_F = 2;
	localparam int ST_PADDLE_R = 3;
	localparam int ST_LIFT_U = 4;
	localparam int ST_LIFT_D = 5;

	// ==========================================================
	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [9:0] MOTOR_RST = 10'h000;
	localparam logic [2:0] SOL_RST = 3'h0;
	localparam logic [5:0] MASK_RST = 6'h00;

	typedef enum logic {
		SMMS_MODE_STACKER = 1'b0,
		SMMS_MODE_MAILBOX = 1'b1
	} smms_mode_t;

	typedef enum logic [1:0] {
		SMMS_WD_IDLE = 2'b00,
		SMMS_WD_ARMED = 2'b01,
		SMMS_WD_DONE = 2'b11
	} smms_wd_state_t;

	typedef enum logic [1:0] {
		SMMS_AX_IDLE = 2'b00,
		SMMS_AX_RESP = 2'b01
	} smms_ax_state_t;

endpackage

// >>> design/smms_supervisor.sv
// smms_supervisor: motor drive and sensor-response supervision top
// assumes: sensors synchronous to clk_sys, host reached over axi4-lite
//
// Overview of operation
// - host selects stacker or mailbox delivery mode
// - stapling allowed in either delivery mode
// - five motors, each with own drive output
// - faults inferred from related sensors, not motor
// - staple arm sensor late: staple motor fault
// - side guide sensor late: guide motor fault
// - paddle forward, upper exit roller late: fault
// - paddle reverse, aligner roller late: fault
// - lift up: top limit or full late
// - lift down: top, bottom, full late
// - feed motor has no watchdog; jams show it
// - a fault notifies the host formatter only if its mask bit is set
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module smms_supervisor (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic [1:0] staple_arm_motor,
	output logic [1:0] side_guide_motor,
	output logic [1:0] paddle_drive_motor,
	output logic [1:0] transport_feed_motor,
	output logic [1:0] bin_elevator_motor,
	output logic sheet_clamp_solenoid,
	output logic entry_gate_solenoid,
	output logic bin_select_solenoid,
	output logic delivery_mode,
	output logic staple_enable,
	input wire logic bin_three_exit_sensor,
	input wire logic transport_feed_sensor_a,
	input wire logic bin_three_full_sensor,
	input wire logic aligner_roller_sensor,
	input wire logic transport_feed_sensor_b,
	input wire logic side_guide_sensor,
	input wire logic upper_exit_roller_sensor,
	input wire logic bin_one_presence_sensor,
	input wire logic bin_two_full_sensor,
	input wire logic bin_two_presence_sensor,
	input wire logic bin_one_full_sensor,
	input wire logic bin_three_top_limit_sensor,
	input wire logic bin_three_bottom_limit_sensor,
	input wire logic staple_arm_position_sensor,
	input wire logic staple_supply_sensor,
	input wire logic staple_position_ok_sensor,
	input wire logic cover_open_switch
);

	// ==========================================================
	// reset release
	logic rst_meta_n, rst_n;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// bus front end
	logic wr_en, rd_en, wr_ok, rd_ok;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;

	smms_axil_slave u_axil (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// ==========================================================
	// registers
	logic [1:0] ctrl, next_ctrl;
	logic [9:0] motor, next_motor;
	logic [2:0] sol, next_sol;
	logic [5:0] status, next_status;
	logic [5:0] mask, next_mask;
	logic [31:0] limit [6];
	logic [31:0] next_limit [6];
	logic [9:0] motor_q;

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] lanes(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// watchdog hookup
	smms_wdog_if wd ();
	logic [5:0] dir_on;
	logic [5:0] hit;

	smms_wdog_bank u_wdog (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.wd(wd.bank)
	);

	always_comb begin
		dir_on[smms_pkg::ST_STAPLE] = motor[smms_pkg::MOT_STAPLE];
		dir_on[smms_pkg::ST_GUIDE] = motor[smms_pkg::MOT_GUIDE];
		dir_on[smms_pkg::ST_PADDLE_F] = motor[smms_pkg::MOT_PADDLE] &&
			!motor[smms_pkg::MOT_PADDLE + 1];
		dir_on[smms_pkg::ST_PADDLE_R] = motor[smms_pkg::MOT_PADDLE] &&
			motor[smms_pkg::MOT_PADDLE + 1];
		dir_on[smms_pkg::ST_LIFT_U] = motor[smms_pkg::MOT_LIFT] &&
			!motor[smms_pkg::MOT_LIFT + 1];
		dir_on[smms_pkg::ST_LIFT_D] = motor[smms_pkg::MOT_LIFT] &&
			motor[smms_pkg::MOT_LIFT + 1];
		hit[smms_pkg::ST_STAPLE] = staple_arm_position_sensor;
		hit[smms_pkg::ST_GUIDE] = side_guide_sensor;
		hit[smms_pkg::ST_PADDLE_F] = upper_exit_roller_sensor;
		hit[smms_pkg::ST_PADDLE_R] = aligner_roller_sensor;
		hit[smms_pkg::ST_LIFT_U] = bin_three_top_limit_sensor ||
			bin_three_full_sensor;
		hit[smms_pkg::ST_LIFT_D] = bin_three_top_limit_sensor ||
			bin_three_bottom_limit_sensor || bin_three_full_sensor;
	end

	// onset of a direction, from last cycle's drive
	logic [5:0] dir_was;
	always_comb begin
		dir_was[smms_pkg::ST_STAPLE] = motor_q[smms_pkg::MOT_STAPLE];
		dir_was[smms_pkg::ST_GUIDE] = motor_q[smms_pkg::MOT_GUIDE];
		dir_was[smms_pkg::ST_PADDLE_F] = motor_q[smms_pkg::MOT_PADDLE] &&
			!motor_q[smms_pkg::MOT_PADDLE + 1];
		dir_was[smms_pkg::ST_PADDLE_R] = motor_q[smms_pkg::MOT_PADDLE] &&
			motor_q[smms_pkg::MOT_PADDLE + 1];
		dir_was[smms_pkg::ST_LIFT_U] = motor_q[smms_pkg::MOT_LIFT] &&
			!motor_q[smms_pkg::MOT_LIFT + 1];
		dir_was[smms_pkg::ST_LIFT_D] = motor_q[smms_pkg::MOT_LIFT] &&
			motor_q[smms_pkg::MOT_LIFT + 1];
	end

	assign wd.start = dir_on & ~dir_was;
	assign wd.hit = hit;
	assign wd.running = dir_on;
	assign wd.limit = limit;

	// ==========================================================
	// register write and status update
	always_comb begin
		next_ctrl = ctrl;
		next_motor = motor;
		next_sol = sol;
		next_mask = mask;
		next_limit = limit;
		next_status = status;
		wr_ok = 1'b1;
		if (wr_en) begin
			case (wr_addr)
				smms_pkg::OFS_CTRL: next_ctrl = 2'(lanes({30'h0, ctrl},
					wr_data, wr_strb));
				smms_pkg::OFS_MOTOR: next_motor = 10'(lanes({22'h0, motor},
					wr_data, wr_strb));
				smms_pkg::OFS_SOL: next_sol = 3'(lanes({29'h0, sol},
					wr_data, wr_strb));
				smms_pkg::OFS_STATUS: begin
					if (wr_strb[0]) begin
						next_status = status & ~wr_data[5:0];
					end
				end
				smms_pkg::OFS_MASK: next_mask = 6'(lanes({26'h0, mask},
					wr_data, wr_strb));
				smms_pkg::OFS_SENSE: begin
				end
				default: begin
					if (wr_addr >= smms_pkg::OFS_TO_STAPLE &&
							wr_addr <= smms_pkg::OFS_TO_LIFT_D &&
							wr_addr[1:0] == 2'b00) begin
						next_limit[3'(wr_addr[7:2] - 6'd6)] = lanes(
							limit[3'(wr_addr[7:2] - 6'd6)],
							wr_data, wr_strb);
					end else begin
						wr_ok = 1'b0;
					end
				end
			endcase
		end
		// set wins over a clear in the same cycle
		next_status = next_status | wd.expire;
	end

	// feed motor deliberately unsupervised; jams show its faults
	assign transport_feed_motor = motor[smms_pkg::MOT_FEED +: 2];

	// ==========================================================
	// register read
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case (rd_addr)
			smms_pkg::OFS_CTRL: rd_data = {30'h0, ctrl};
			smms_pkg::OFS_MOTOR: rd_data = {22'h0, motor};
			smms_pkg::OFS_SOL: rd_data = {29'h0, sol};
			smms_pkg::OFS_SENSE: rd_data = {15'h0, cover_open_switch,
				staple_position_ok_sensor, staple_supply_sensor,
				staple_arm_position_sensor, bin_three_bottom_limit_sensor,
				bin_three_top_limit_sensor, bin_one_full_sensor,
				bin_two_presence_sensor, bin_two_full_sensor,
				bin_one_presence_sensor, upper_exit_roller_sensor,
				side_guide_sensor, transport_feed_sensor_b,
				aligner_roller_sensor, bin_three_full_sensor,
				transport_feed_sensor_a, bin_three_exit_sensor};
			smms_pkg::OFS_STATUS: rd_data = {26'h0, status};
			smms_pkg::OFS_MASK: rd_data = {26'h0, mask};
			default: begin
				if (rd_addr >= smms_pkg::OFS_TO_STAPLE &&
						rd_addr <= smms_pkg::OFS_TO_LIFT_D &&
						rd_addr[1:0] == 2'b00) begin
					rd_data = limit[3'(rd_addr[7:2] - 6'd6)];
				end else begin
					rd_ok = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= smms_pkg::CTRL_RST;
			motor <= smms_pkg::MOTOR_RST;
			motor_q <= smms_pkg::MOTOR_RST;
			sol <= smms_pkg::SOL_RST;
			status <= 6'h00;
			mask <= smms_pkg::MASK_RST;
			for (int i = 0; i < smms_pkg::NUM_WDOG; i++) begin
				limit[i] <= smms_pkg::WDOG_DEF_CYC;
			end
		end else begin
			ctrl <= next_ctrl;
			motor <= next_motor;
			motor_q <= motor;
			sol <= next_sol;
			status <= next_status;
			mask <= next_mask;
			limit <= next_limit;
		end
	end

	// ==========================================================
	// outputs
	assign irq = |(status & mask);
	assign staple_arm_motor = motor[smms_pkg::MOT_STAPLE +: 2];
	assign side_guide_motor = motor[smms_pkg::MOT_GUIDE +: 2];
	assign paddle_drive_motor = motor[smms_pkg::MOT_PADDLE +: 2];
	assign bin_elevator_motor = motor[smms_pkg::MOT_LIFT +: 2];
	assign sheet_clamp_solenoid = sol[0];
	assign entry_gate_solenoid = sol[1];
	assign bin_select_solenoid = sol[2];
	assign delivery_mode = ctrl[smms_pkg::CTRL_MODE];
	// staple enable not gated by mode
	assign staple_enable = ctrl[smms_pkg::CTRL_STAPLE_EN];

endmodule

// >>> design/smms_wdog_bank.sv
// smms_wdog_bank: one sensor-response watchdog per supervised direction
// assumes: start is a one-cycle pulse on drive onset, reset asynchronous
`timescale 1ns/1ps
module smms_wdog_bank (
	input wire logic clk_sys,
	input wire logic rst_n,
	smms_wdog_if.bank wd
);

	// ==========================================================
	// per channel counter
	genvar g;
	generate
		for (g = 0; g < smms_pkg::NUM_WDOG; g++) begin : gen_ch
			smms_pkg::smms_wd_state_t st;
			smms_pkg::smms_wd_state_t next_st;
			logic [31:0] cnt;
			logic [31:0] next_cnt;
			logic fire;

			always_comb begin
				next_st = st;
				next_cnt = cnt;
				fire = 1'b0;
				case (st)
					smms_pkg::SMMS_WD_IDLE: begin
						if (wd.start[g]) begin
							next_st = smms_pkg::SMMS_WD_ARMED;
							next_cnt = 32'h0000_0000;
						end
					end
					smms_pkg::SMMS_WD_ARMED: begin
						// drive withdrawn or sensor seen: no fault
						if (wd.hit[g] || !wd.running[g]) begin
							next_st = smms_pkg::SMMS_WD_IDLE;
						end else if (cnt >= wd.limit[g]) begin
							fire = 1'b1;
							next_st = smms_pkg::SMMS_WD_DONE;
						end else begin
							next_cnt = cnt + 32'h0000_0001;
						end
					end
					smms_pkg::SMMS_WD_DONE: begin
						// one report per motor start
						if (!wd.running[g]) begin
							next_st = smms_pkg::SMMS_WD_IDLE;
						end
					end
					default: begin
						next_st = smms_pkg::SMMS_WD_IDLE;
					end
				endcase
			end

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					st <= smms_pkg::SMMS_WD_IDLE;
					cnt <= 32'h0000_0000;
				end else begin
					st <= next_st;
					cnt <= next_cnt;
				end
			end

			assign wd.expire[g] = fire;
		end
	endgenerate

endmodule

// >>> design/smms_wdog_if.sv
// smms_wdog_if: watchdog bank control and result bundle
// assumes: one clock, driven by the supervisor top
`timescale 1ns/1ps
interface smms_wdog_if;
	logic [5:0] start;
	logic [5:0] hit;
	logic [5:0] running;
	logic [31:0] limit [6];
	logic [5:0] expire;

	modport ctl (
		output start,
		output hit,
		output running,
		output limit,
		input expire
	);
	modport bank (
		input start,
		input hit,
		input running,
		input limit,
		output expire
	);
endinterface

// >>> verif/smms_assertions.sv
// smms_assertions: bus handshake and supervision checks at the top ports
// assumes: bound to smms_supervisor, one clock domain on clk_sys
`timescale 1ns/1ps
module smms_assertions (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq,
	input wire logic [1:0] staple_arm_motor,
	input wire logic [1:0] side_guide_motor,
	input wire logic [1:0] paddle_drive_motor,
	input wire logic [1:0] transport_feed_motor,
	input wire logic [1:0] bin_elevator_motor,
	input wire logic delivery_mode,
	input wire logic staple_enable
);
	// ========
	// helpers
	wire logic sup = staple_arm_motor[0] | side_guide_motor[0] |
		paddle_drive_motor[0] | bin_elevator_motor[0];
	wire logic [11:0] drv = {bin_elevator_motor, transport_feed_motor,
		paddle_drive_motor, side_guide_motor, staple_arm_motor,
		delivery_mode, staple_enable};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	// ========
	// checks
	write_latency_a: assert property (wr_taken |=> wr_answer)
		else $error("write response not on second edge");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data late");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("write response repeated");
	read_done_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read data repeated");
	aw_refused_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken early");
	irq_cause_a: assert property (
		$rose(irq) |-> $rose(s_axi_bvalid) || sup)
		else $error("interrupt without supervised drive");
	irq_sticky_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
		else $error("interrupt dropped without write");
	drive_hold_a: assert property (
		$changed(drv) |-> $rose(s_axi_bvalid))
		else $error("drive changed without write");
endmodule

bind smms_supervisor smms_assertions u_chk (.clk_sys, .arst_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .irq, .staple_arm_motor,
	.side_guide_motor, .paddle_drive_motor, .transport_feed_motor,
	.bin_elevator_motor, .delivery_mode, .staple_enable);

// >>> verif/smms_mech_model.sv
// smms_mech_model: sensor answers of the supervised mechanisms
// assumes: drives are bit0 run, bit1 reverse; stuck holds all sensors low
`timescale 1ns/1ps
module smms_mech_model #(
	parameter int DELAY = 3
) (
	input wire logic clk_sys,
	input wire logic stuck,
	input wire logic alt,
	input wire logic [1:0] staple_arm_motor,
	input wire logic [1:0] side_guide_motor,
	input wire logic [1:0] paddle_drive_motor,
	input wire logic [1:0] bin_elevator_motor,
	output logic staple_arm_position_sensor,
	output logic side_guide_sensor,
	output logic upper_exit_roller_sensor,
	output logic aligner_roller_sensor,
	output logic bin_three_top_limit_sensor,
	output logic bin_three_bottom_limit_sensor,
	output logic bin_three_full_sensor
);
	// ========
	// travel time since drive onset
	int age = 0;
	wire logic ok = !stuck && age >= DELAY;
	always @(posedge clk_sys) begin
		if (!(staple_arm_motor[0] | side_guide_motor[0] |
			paddle_drive_motor[0] | bin_elevator_motor[0]))
			age <= 0;
		else if (age < 255)
			age <= age + 1;
	end
	// alt picks the full sensor so both lift answers get used
	assign staple_arm_position_sensor = ok && staple_arm_motor == 2'h1;
	assign side_guide_sensor = ok && side_guide_motor == 2'h1;
	assign upper_exit_roller_sensor = ok && paddle_drive_motor == 2'h1;
	assign aligner_roller_sensor = ok && paddle_drive_motor == 2'h3;
	assign bin_three_top_limit_sensor =
		ok && !alt && bin_elevator_motor == 2'h1;
	assign bin_three_bottom_limit_sensor =
		ok && !alt && bin_elevator_motor == 2'h3;
	assign bin_three_full_sensor = ok && alt && bin_elevator_motor[0];
endmodule

// >>> verif/smms_supervisor_bench.sv
// smms_supervisor_bench: self-checking bench, bench is bus master
// assumes: mechanism model answers the supervised sensors
`timescale 1ns/1ps
module smms_supervisor_bench;
	// ========
	// signals
	logic clk_sys = 0, arst_n = 0, stuck = 0, alt = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq, delivery_mode, staple_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [1:0] staple_arm_motor, side_guide_motor, paddle_drive_motor;
	logic [1:0] transport_feed_motor, bin_elevator_motor;
	logic sheet_clamp_solenoid, entry_gate_solenoid, bin_select_solenoid;
	logic staple_arm_position_sensor, side_guide_sensor;
	logic upper_exit_roller_sensor, aligner_roller_sensor;
	logic bin_three_top_limit_sensor, bin_three_bottom_limit_sensor;
	logic bin_three_full_sensor;
	logic [9:0] misc = 0;
	wire logic cover_open_switch, staple_position_ok_sensor;
	wire logic staple_supply_sensor, bin_one_full_sensor;
	wire logic bin_two_presence_sensor, bin_two_full_sensor;
	wire logic bin_one_presence_sensor, transport_feed_sensor_b;
	wire logic transport_feed_sensor_a, bin_three_exit_sensor;
	assign {cover_open_switch, staple_position_ok_sensor,
		staple_supply_sensor, bin_one_full_sensor, bin_two_presence_sensor,
		bin_two_full_sensor, bin_one_presence_sensor,
		transport_feed_sensor_b, transport_feed_sensor_a,
		bin_three_exit_sensor} = misc;
	// one drive per watchdog channel: staple, guide, paddle f/r, lift u/d
	localparam logic [9:0] MOT [6] = '{10'h001, 10'h004, 10'h010,
		10'h030, 10'h100, 10'h300};
	int fails = 0, num_checks = 0;

	smms_supervisor DUT (.*);
	smms_mech_model #(.DELAY(3)) u_mech (.*);

	always #50 clk_sys = ~clk_sys;

	// ========
	// bus and check tasks
	task chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		tb = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!tb) begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tb) begin
				resp = s_axi_bresp;
				s_axi_bready <= 0;
			end
		end
	endtask

	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic ta, tr;
		tr = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!tr) begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 0;
			if (tr) begin
				resp = s_axi_rresp;
				s_axi_rready <= 0;
				chk(nm, s_axi_rdata, e);
			end
		end
	endtask

	// ========
	// scenarios
	task t_regs;
		rchk("ctrl", smms_pkg::OFS_CTRL, 0);
		rchk("mask", smms_pkg::OFS_MASK, 0);
		rchk("limit", smms_pkg::OFS_TO_LIFT_D, smms_pkg::WDOG_DEF_CYC);
		s_axi_wstrb <= 4'h1;
		wr(smms_pkg::OFS_TO_LIFT_D, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hf;
		rchk("lanes", smms_pkg::OFS_TO_LIFT_D,
			{smms_pkg::WDOG_DEF_CYC[31:8], 8'hFF});
		rchk("gap", 8'h40, 0);
		chk("gap_rresp", resp, 2);
		wr(8'h40, 1);
		chk("gap_bresp", resp, 2);
	endtask

	task t_mode;
		for (int i = 0; i < 4; i++) begin
			wr(smms_pkg::OFS_CTRL, i);
			chk("mode", delivery_mode, i[0]);
			chk("staple_en", staple_enable, i[1]);
		end
	endtask

	task t_drive;
		misc <= '1;
		rchk("sense", smms_pkg::OFS_SENSE, 17'h1_C793);
		misc <= '0;
		wr(smms_pkg::OFS_SOL, 7);
		chk("sol", {bin_select_solenoid, entry_gate_solenoid,
			sheet_clamp_solenoid}, 7);
		wr(smms_pkg::OFS_MOTOR, 10'h2B9);
		chk("motors", {bin_elevator_motor, transport_feed_motor,
			paddle_drive_motor, side_guide_motor,
			staple_arm_motor}, 10'h2B9);
		wr(smms_pkg::OFS_MOTOR, 0);
		wr(smms_pkg::OFS_SOL, 0);
	endtask

	task t_wdog;
		int c;
		for (int ch = 0; ch < 6; ch++)
			wr(smms_pkg::OFS_TO_STAPLE + 8'(4 * ch), 10);
		wr(smms_pkg::OFS_MASK, 32'h3F);
		for (int ch = 0; ch < 6; ch++) begin
			for (int k = 0; k < 2; k++) begin
				stuck <= k[0];
				alt <= ch[0];
				wr(smms_pkg::OFS_MOTOR, MOT[ch]);
				for (c = 0; c < 40 && irq !== 1; c++) @(negedge clk_sys);
				chk("irq", irq, k);
				if (k) chk("early", c >= 10, 1);
				rchk("status", smms_pkg::OFS_STATUS, k << ch);
				wr(smms_pkg::OFS_MOTOR, 0);
				wr(smms_pkg::OFS_STATUS, 32'h3F);
				chk("cleared", irq, 0);
			end
		end
	endtask

	task t_feed;
		wr(smms_pkg::OFS_MASK, 0);
		stuck <= 1;
		wr(smms_pkg::OFS_MOTOR, 10'h041);
		repeat (40) @(negedge clk_sys);
		rchk("feed", smms_pkg::OFS_STATUS, 1);
		chk("masked", irq, 0);
		wr(smms_pkg::OFS_MOTOR, 0);
		wr(smms_pkg::OFS_STATUS, 32'h3F);
		stuck <= 0;
	endtask

	// ========
	// run control
	task results;
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1;
		repeat (3) @(posedge clk_sys);
		t_regs;
		t_mode;
		t_drive;
		t_wdog;
		t_feed;
		results;
	end

	// whole run needs under a thousand cycles
	initial begin
		#2000000;
		fails++;
		results;
	end
endmodule
